// ---- hdl/pgaoc_pkg.sv ----
package pgaoc_pkg;

	// command codes of the management port
	localparam logic [7:0] CMD_VOUT_SETPOINT = 8'h21;
	localparam logic [7:0] CMD_TRANSITION_RATE = 8'h27;
	localparam logic [7:0] CMD_SWITCH_FREQ = 8'h33;
	localparam logic [7:0] CMD_PGOOD_ON = 8'h5e;
	localparam logic [7:0] CMD_PGOOD_OFF = 8'h5f;
	localparam logic [7:0] CMD_TON_RISE = 8'h61;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_GOOD_POLARITY = 8'hd0;
	localparam logic [7:0] CMD_AUX_BASE = 8'he0;
	localparam logic [7:0] CMD_ADDR_INCREMENT = 8'hee;
	localparam logic [7:0] CMD_LOAD_VOLT_SETUP = 8'hef;
	localparam logic [7:0] CMD_CAP_ADAPT_SETUP = 8'hf7;
	localparam logic [7:0] CMD_HEADER_SELECT = 8'hf9;

	// auxiliary settings, index = code - CMD_AUX_BASE
	localparam int AUX_COUNT = 14;
	localparam logic [3:0] AUX_LOW_TO_MID = 4'h0;
	localparam logic [3:0] AUX_MID_TO_LOW = 4'h1;
	localparam logic [3:0] AUX_MID_TO_HIGH = 4'h2;
	localparam logic [3:0] AUX_HIGH_TO_MID = 4'h3;
	localparam logic [3:0] AUX_LEVEL_FIRST = 4'h4;
	localparam logic [3:0] AUX_LEVEL_SECOND = 4'h5;
	localparam logic [3:0] AUX_RAMP_START = 4'h6;
	localparam logic [3:0] AUX_RAMP_END = 4'h7;
	localparam logic [3:0] AUX_CAP_LIMIT1 = 4'h8;
	localparam logic [3:0] AUX_CAP_LIMIT2 = 4'h9;
	localparam logic [3:0] AUX_CAP_THIRD_CAPACITANCE_LIMIT = 4'ha;
	localparam logic [3:0] AUX_RAMP_FACTOR1 = 4'hb;
	localparam logic [3:0] AUX_RAMP_FACTOR2 = 4'hc;
	localparam logic [3:0] AUX_RAMP_FACTOR3 = 4'hd;
	localparam logic [15:0] AUX_RESET = 16'h0000;
	localparam logic [15:0] FACTOR_RESET = 16'h0010;

	// reset values (voltages in mV, times in ms, frequency in kHz)
	localparam logic [15:0] VOUT_SETPOINT_RESET = 16'h2ee0;
	localparam logic [15:0] TRANSITION_RATE_RESET = 16'h000a;
	localparam logic [15:0] PGOOD_ON_RESET = 16'h1f40;
	localparam logic [15:0] PGOOD_OFF_RESET = 16'h1388;
	localparam logic [15:0] TON_RISE_RESET = 16'h000a;
	localparam logic [15:0] FREQ_RESET = 16'h00b4;
	localparam logic [15:0] FREQ_MIN = 16'h00a0;
	localparam logic [15:0] FREQ_MAX = 16'h00c8;
	localparam logic [7:0] POLARITY_RESET = 8'h00;
	localparam logic [7:0] POLARITY_ACTIVE_HIGH = 8'h01;
	localparam logic [7:0] HEADER_RESET = 8'h04;
	localparam logic [7:0] INCREMENT_RESET = 8'h00;
	localparam logic [7:0] SETUP_RESET = 8'h00;

	// field positions
	localparam int HDR_OPEN_DRAIN_BIT = 1;
	localparam int HDR_SYNC_SECOND_BIT = 3;
	localparam int HDR_SYNC_OUT_BIT = 4;
	localparam int LBV_ENABLE_BIT = 0;
	localparam int CAP_RAMP_ENABLE_BIT = 0;
	localparam int CAP_LOOP_ENABLE_BIT = 1;
	localparam int STATUS_GOOD_BIT = 11;
	localparam int FACTOR_SHIFT = 4;

	// timing
	localparam int CLK_KHZ = 10000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SLEW_STEP_NS = 1000000;
	localparam int SLEW_STEP_CYCLES = SLEW_STEP_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {BAND_LOW, BAND_MID, BAND_HIGH} pgaoc_band_e;
	typedef enum logic [1:0] {M_IDLE, M_WAIT, M_COUNT} pgaoc_meas_e;

endpackage

// ---- hdl/pgaoc_hyst.sv ----
// hysteretic comparator: set above on_lim, clear below off_lim
module pgaoc_hyst #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// compare
	input wire logic [W-1:0] value_in,
	input wire logic [W-1:0] on_lim_in,
	input wire logic [W-1:0] off_lim_in,
	input wire logic force_off_in,
	// result
	output logic state_out
);

	// force wins, so a hold can never be overridden by a sample
	always_ff @(posedge clk_in) begin
		if (rst_in || force_off_in) begin
			state_out <= 1'b0;
		end else if (value_in > on_lim_in) begin
			state_out <= 1'b1;
		end else if (value_in < off_lim_in) begin
			state_out <= 1'b0;
		end
	end

endmodule // pgaoc_hyst

// ---- hdl/pgaoc_top.sv ----
module pgaoc_top import pgaoc_pkg::*; #(
	parameter int SLEW_TICK_CYCLES = SLEW_STEP_CYCLES
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// management command port
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [15:0] cmd_wdata_in,
	output logic cmd_ack_out,
	output logic [15:0] cmd_rdata_out,
	// converter status
	input wire logic [15:0] vout_meas_in,
	input wire logic [15:0] iout_meas_in,
	input wire logic ramping_in,
	input wire logic fault_in,
	// power good pin
	output logic good_or_sync_pin_out,
	output logic good_or_sync_pin_oe_n_out,
	// second address pin
	input wire logic strap_second_pin_in,
	output logic strap_second_pin_out,
	output logic strap_second_pin_oe_n_out,
	// address straps, decoded
	input wire logic [6:0] address_strap_first_in,
	input wire logic [6:0] address_strap_second_in,
	output logic [6:0] bus_address_out,
	// control outputs
	output logic switch_tick_out,
	output logic [15:0] vout_ref_out,
	output logic [15:0] rise_time_out,
	output logic loop_alt_out,
	output logic [15:0] cap_measure_out
);

	logic [15:0] setpoint_reg, rate_reg, freq_reg, good_on_reg, good_off_reg;
	logic [15:0] ton_rise_reg;
	logic [7:0] polarity_reg, increment_reg, lbv_setup_reg, cap_setup_reg;
	logic [7:0] header_reg;
	logic [15:0] aux_reg [AUX_COUNT];
	logic [7:0] aux_idx;
	logic aux_hit;
	logic good_state, good_flag, good_level;
	logic open_drain, sync_second, sync_out;

	assign aux_idx = cmd_code_in - CMD_AUX_BASE;
	assign aux_hit = (cmd_code_in >= CMD_AUX_BASE) &&
		(aux_idx < 8'(AUX_COUNT));
	assign open_drain = header_reg[HDR_OPEN_DRAIN_BIT];
	assign sync_second = header_reg[HDR_SYNC_SECOND_BIT];
	assign sync_out = header_reg[HDR_SYNC_OUT_BIT];

	////////////////////////////////////////////////////////////////////
	// command writes
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			setpoint_reg <= VOUT_SETPOINT_RESET;
			rate_reg <= TRANSITION_RATE_RESET;
			freq_reg <= FREQ_RESET;
			good_on_reg <= PGOOD_ON_RESET;
			good_off_reg <= PGOOD_OFF_RESET;
			ton_rise_reg <= TON_RISE_RESET;
			polarity_reg <= POLARITY_RESET;
			increment_reg <= INCREMENT_RESET;
			lbv_setup_reg <= SETUP_RESET;
			cap_setup_reg <= SETUP_RESET;
			header_reg <= HEADER_RESET;
		end else if (cmd_valid_in && cmd_write_in) begin
			unique case (cmd_code_in)
				CMD_VOUT_SETPOINT: setpoint_reg <= cmd_wdata_in;
				CMD_TRANSITION_RATE: rate_reg <= cmd_wdata_in;
				CMD_SWITCH_FREQ: begin
					// out of range values are dropped, not clamped
					if (cmd_wdata_in >= FREQ_MIN &&
						cmd_wdata_in <= FREQ_MAX) begin
						freq_reg <= cmd_wdata_in;
					end
				end
				CMD_PGOOD_ON: good_on_reg <= cmd_wdata_in;
				CMD_PGOOD_OFF: good_off_reg <= cmd_wdata_in;
				CMD_TON_RISE: ton_rise_reg <= cmd_wdata_in;
				CMD_GOOD_POLARITY: polarity_reg <= cmd_wdata_in[7:0];
				CMD_ADDR_INCREMENT: increment_reg <= cmd_wdata_in[7:0];
				CMD_LOAD_VOLT_SETUP: lbv_setup_reg <= cmd_wdata_in[7:0];
				CMD_CAP_ADAPT_SETUP: cap_setup_reg <= cmd_wdata_in[7:0];
				CMD_HEADER_SELECT: header_reg <= cmd_wdata_in[7:0];
				default: ;
			endcase
		end
	end

	// auxiliary limits and levels
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < AUX_COUNT; i++) begin
				aux_reg[i] <= (i >= int'(AUX_RAMP_FACTOR1)) ?
					FACTOR_RESET : AUX_RESET;
			end
		end else if (cmd_valid_in && cmd_write_in && aux_hit) begin
			aux_reg[aux_idx[3:0]] <= cmd_wdata_in;
		end
	end

	// reads answer one cycle later; unknown codes read zero
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cmd_ack_out <= 1'b0;
			cmd_rdata_out <= 16'h0000;
		end else begin
			cmd_ack_out <= cmd_valid_in;
			if (cmd_valid_in && !cmd_write_in) begin
				if (aux_hit) begin
					cmd_rdata_out <= aux_reg[aux_idx[3:0]];
				end else begin
					unique case (cmd_code_in)
						CMD_VOUT_SETPOINT: cmd_rdata_out <= setpoint_reg;
						CMD_TRANSITION_RATE: cmd_rdata_out <= rate_reg;
						CMD_SWITCH_FREQ: cmd_rdata_out <= freq_reg;
						CMD_PGOOD_ON: cmd_rdata_out <= good_on_reg;
						CMD_PGOOD_OFF: cmd_rdata_out <= good_off_reg;
						CMD_TON_RISE: cmd_rdata_out <= ton_rise_reg;
						CMD_STATUS_WORD: begin
							cmd_rdata_out <= 16'h0000;
							cmd_rdata_out[STATUS_GOOD_BIT] <= good_flag;
						end
						CMD_GOOD_POLARITY: cmd_rdata_out <= {8'h00, polarity_reg};
						CMD_ADDR_INCREMENT: cmd_rdata_out <= {8'h00, increment_reg};
						CMD_LOAD_VOLT_SETUP: cmd_rdata_out <= {8'h00, lbv_setup_reg};
						CMD_CAP_ADAPT_SETUP: cmd_rdata_out <= {8'h00, cap_setup_reg};
						CMD_HEADER_SELECT: cmd_rdata_out <= {8'h00, header_reg};
						default: cmd_rdata_out <= 16'h0000;
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// power good
	pgaoc_hyst #(.W(16)) u_good_cmp (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.value_in(vout_meas_in),
		.on_lim_in(good_on_reg),
		.off_lim_in(good_off_reg),
		.force_off_in(ramping_in || fault_in),
		.state_out(good_state)
	);

	assign good_flag = good_state && !fault_in && !ramping_in;
	assign good_level = (polarity_reg == POLARITY_ACTIVE_HIGH) ?
		good_state : !good_state;

	// open-drain releases the pin instead of driving high; tied pins need it
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			good_or_sync_pin_out <= 1'b1;
			good_or_sync_pin_oe_n_out <= 1'b0;
		end else begin
			good_or_sync_pin_out <= good_level;
			good_or_sync_pin_oe_n_out <= open_drain && good_level;
		end
	end

	////////////////////////////////////////////////////////////////////
	// switching rate and sync on the second address pin
	logic [2:0] sync_sr;
	logic sync_filt;
	logic sync_edge;
	logic [15:0] sw_cnt, sw_period;

	// three stages; the level moves only once the last two agree
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sync_sr <= 3'h0;
			sync_filt <= 1'b0;
		end else begin
			sync_sr <= {sync_sr[1:0], strap_second_pin_in};
			if (sync_sr[1] == sync_sr[2]) begin
				sync_filt <= sync_sr[2];
			end
		end
	end
	assign sync_edge = sync_sr[1] && sync_sr[2] && !sync_filt;
	assign sw_period = 16'(CLK_KHZ / int'(freq_reg));

	// with the second pin as sync input, an external edge restarts the period, locking to the master
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sw_cnt <= 16'h0000;
			switch_tick_out <= 1'b0;
		end else if ((sync_second && !sync_out && sync_edge) ||
			(sw_cnt >= sw_period - 16'h0001)) begin
			sw_cnt <= 16'h0000;
			switch_tick_out <= 1'b1;
		end else begin
			sw_cnt <= sw_cnt + 16'h0001;
			switch_tick_out <= 1'b0;
		end
	end

	// sync out with the second pin as sync drives the pin; otherwise it stays a released input
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			strap_second_pin_out <= 1'b0;
			strap_second_pin_oe_n_out <= 1'b1;
		end else begin
			strap_second_pin_out <= switch_tick_out;
			strap_second_pin_oe_n_out <= !(sync_second && sync_out);
		end
	end

	// bus address from straps
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			bus_address_out <= 7'h00;
		end else if (sync_second) begin
			bus_address_out <= address_strap_first_in +
				increment_reg[6:0];
		end else begin
			bus_address_out <= address_strap_first_in +
				address_strap_second_in;
		end
	end

	////////////////////////////////////////////////////////////////////
	// load based voltage step
	logic band_mid, band_high;
	logic [15:0] target, slew_cnt;
	logic slew_tick;

	pgaoc_hyst #(.W(16)) u_band_mid (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.value_in(iout_meas_in),
		.on_lim_in(aux_reg[AUX_LOW_TO_MID]),
		.off_lim_in(aux_reg[AUX_MID_TO_LOW]),
		.force_off_in(1'b0),
		.state_out(band_mid)
	);

	pgaoc_hyst #(.W(16)) u_band_high (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.value_in(iout_meas_in),
		.on_lim_in(aux_reg[AUX_MID_TO_HIGH]),
		.off_lim_in(aux_reg[AUX_HIGH_TO_MID]),
		.force_off_in(1'b0),
		.state_out(band_high)
	);

	// top band and disabled feature both fall back to the setpoint
	always_comb begin
		if (!lbv_setup_reg[LBV_ENABLE_BIT] || band_high) begin
			target = setpoint_reg;
		end else if (band_mid) begin
			target = aux_reg[AUX_LEVEL_SECOND];
		end else begin
			target = aux_reg[AUX_LEVEL_FIRST];
		end
	end

	assign slew_tick = (slew_cnt == 16'(SLEW_TICK_CYCLES - 1));
	always_ff @(posedge clk_in) begin
		if (rst_in || slew_tick) begin
			slew_cnt <= 16'h0000;
		end else begin
			slew_cnt <= slew_cnt + 16'h0001;
		end
	end

	// one rate step per tick, landing exactly on target
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			vout_ref_out <= VOUT_SETPOINT_RESET;
		end else if (slew_tick && vout_ref_out != target) begin
			if (target > vout_ref_out) begin
				vout_ref_out <= (target - vout_ref_out > rate_reg) ?
					vout_ref_out + rate_reg : target;
			end else begin
				vout_ref_out <= (vout_ref_out - target > rate_reg) ?
					vout_ref_out - rate_reg : target;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// adaptive ramp time and loop compensation
	pgaoc_meas_e meas_state;
	logic ramp_prev;
	logic [23:0] meas_cnt;
	logic [15:0] factor;
	logic [31:0] scaled;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ramp_prev <= 1'b0;
		end else begin
			ramp_prev <= ramping_in;
		end
	end

	// count cycles spent between start and end levels
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meas_state <= M_IDLE;
			meas_cnt <= 24'h000000;
		end else if (ramping_in && !ramp_prev) begin
			meas_state <= M_WAIT;
			meas_cnt <= 24'h000000;
		end else begin
			unique case (meas_state)
				M_IDLE: ;
				M_WAIT: begin
					if (!ramping_in) begin
						meas_state <= M_IDLE;
					end else if (vout_meas_in >= aux_reg[AUX_RAMP_START]) begin
						meas_state <= M_COUNT;
					end
				end
				M_COUNT: begin
					if (!ramping_in || vout_meas_in >= aux_reg[AUX_RAMP_END]) begin
						meas_state <= M_IDLE;
					end else if (meas_cnt != 24'hffffff) begin
						meas_cnt <= meas_cnt + 24'h000001;
					end
				end
			endcase
		end
	end

	always_comb begin
		if (meas_cnt[23:8] <= aux_reg[AUX_CAP_LIMIT1]) begin
			factor = aux_reg[AUX_RAMP_FACTOR1];
		end else if (meas_cnt[23:8] <= aux_reg[AUX_CAP_LIMIT2]) begin
			factor = aux_reg[AUX_RAMP_FACTOR2];
		end else begin
			factor = aux_reg[AUX_RAMP_FACTOR3];
		end
	end
	assign scaled = (32'(ton_rise_reg) * 32'(factor)) >> FACTOR_SHIFT;

	// rise time restarts at the programmed value every ramp
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rise_time_out <= TON_RISE_RESET;
			loop_alt_out <= 1'b0;
			cap_measure_out <= 16'h0000;
		end else if (ramping_in && !ramp_prev) begin
			rise_time_out <= ton_rise_reg;
			loop_alt_out <= 1'b0;
		end else if (meas_state == M_COUNT && (!ramping_in ||
			vout_meas_in >= aux_reg[AUX_RAMP_END])) begin
			cap_measure_out <= meas_cnt[23:8];
			if (cap_setup_reg[CAP_RAMP_ENABLE_BIT]) begin
				rise_time_out <= scaled[15:0];
			end
			loop_alt_out <= cap_setup_reg[CAP_LOOP_ENABLE_BIT] &&
				(meas_cnt[23:8] > aux_reg[AUX_CAP_THIRD_CAPACITANCE_LIMIT]);
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	AST_GOOD_HOLD: assert property (ramping_in || fault_in
		|=> !good_state)
		else $error("power good active during ramp or fault");
	AST_GOOD_ON: assert property (!ramping_in && !fault_in &&
		vout_meas_in > good_on_reg |=> good_state)
		else $error("power good not set above on level");
	AST_GOOD_OFF: assert property (vout_meas_in < good_off_reg &&
		vout_meas_in <= good_on_reg |=> !good_state)
		else $error("power good not cleared below off level");
	AST_OD_RELEASE: assert property (open_drain && good_level
		|=> good_or_sync_pin_oe_n_out)
		else $error("open drain pin driven high");
	AST_POLARITY: assert property (##1 good_or_sync_pin_out ==
		(($past(polarity_reg) == POLARITY_ACTIVE_HIGH) ==
		$past(good_state)))
		else $error("power good pin polarity wrong");
	AST_FLAG: assert property (cmd_valid_in && !cmd_write_in &&
		cmd_code_in == CMD_STATUS_WORD |=> cmd_rdata_out[STATUS_GOOD_BIT] ==
		($past(good_state) && !$past(fault_in) && !$past(ramping_in)))
		else $error("status good flag disagrees with power good");
	AST_FREQ: assert property (freq_reg >= FREQ_MIN &&
		freq_reg <= FREQ_MAX)
		else $error("switching frequency out of range");
	AST_TOP_BAND: assert property (band_high && slew_tick &&
		vout_ref_out == setpoint_reg |=> vout_ref_out == $past(setpoint_reg))
		else $error("top band left the setpoint");
	AST_SLEW: assert property (vout_ref_out != $past(vout_ref_out)
		|-> $past(slew_tick))
		else $error("output level moved off step tick");
	AST_RISE_START: assert property (ramping_in && !ramp_prev
		|=> rise_time_out == $past(ton_rise_reg))
		else $error("ramp did not start at programmed rise time");
	AST_LOOP_ALT: assert property ($rose(loop_alt_out)
		|-> $past(meas_cnt[23:8]) > $past(aux_reg[AUX_CAP_THIRD_CAPACITANCE_LIMIT]))
		else $error("loop changed below third limit");
	AST_ADDR: assert property (sync_second |=> bus_address_out ==
		$past(address_strap_first_in) + $past(increment_reg[6:0]))
		else $error("sync mode address wrong");

endmodule // pgaoc_top

// ---- test/pgaoc_host.sv ----
// host side of the command port: one strobed command at a time
module pgaoc_host (
	// clock
	input wire logic clk_in,
	// command strobe and payload
	output logic cmd_valid_out,
	output logic cmd_write_out,
	output logic [7:0] cmd_code_out,
	output logic [15:0] cmd_wdata_out,
	// answer
	input wire logic cmd_ack_in,
	input wire logic [15:0] cmd_rdata_in
);
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////
	// idle port at time zero
	initial begin
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_code_out = 8'h00;
		cmd_wdata_out = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////
	// strobe one cycle, answer stands in the following cycle
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [15:0] d, output logic ok, output logic [15:0] rd);
		@(negedge clk_in);
		cmd_valid_out = 1'b1;
		cmd_write_out = w;
		cmd_code_out = c;
		cmd_wdata_out = d;
		@(negedge clk_in);
		// released lines inverted, a stale copy must never look valid
		cmd_valid_out = 1'b0;
		cmd_write_out = ~w;
		cmd_code_out = ~c;
		cmd_wdata_out = ~d;
		ok = cmd_ack_in;
		rd = cmd_rdata_in;
	endtask
endmodule // pgaoc_host

// ---- test/tb_pgaoc_top.sv ----
module tb_pgaoc_top import pgaoc_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct {
		logic w;
		logic [7:0] code;
		logic [15:0] wd;
		logic [15:0] msk;
		logic [15:0] exp;
		logic [15:0] vout;
		logic rmp;
		logic flt;
		logic pin;
	} pgaoc_row_s;

	localparam logic [15:0] ALL = 16'hffff;
	localparam logic [15:0] GD = 16'h0800;
	localparam logic [15:0] Z = 16'h0000;
	localparam logic [15:0] V9 = 16'h2328;
	localparam logic [15:0] V4 = 16'h0fa0;
	localparam int NROW = 27;

	////////////////////////////////////////////////////////////////////////
	// design signals
	logic clk_in, rst_in, cmd_valid_in, cmd_write_in, cmd_ack_out;
	logic [7:0] cmd_code_in;
	logic [15:0] cmd_wdata_in, cmd_rdata_out, vout_meas_in, iout_meas_in;
	logic ramping_in, fault_in, strap_second_pin_in, good_or_sync_pin_out;
	logic good_or_sync_pin_oe_n_out, strap_second_pin_oe_n_out;
	logic switch_tick_out, loop_alt_out, strap_second_pin_out;
	logic [6:0] address_strap_first_in, address_strap_second_in;
	logic [6:0] bus_address_out;
	logic [15:0] vout_ref_out, rise_time_out, cap_measure_out;
	int num_errors = 0;
	int checks = 0;
	int n;
	logic [15:0] rd;

	// write, code, data, mask, expected read, vout, ramp, fault, pin
	pgaoc_row_s rows [NROW] = '{
		'{0, 8'h21, Z, ALL, 16'h2ee0, Z, 0, 0, 1},
		'{0, 8'h27, Z, ALL, 16'h000a, Z, 0, 0, 1},
		'{0, 8'h5e, Z, ALL, 16'h1f40, Z, 0, 0, 1},
		'{0, 8'h5f, Z, ALL, 16'h1388, Z, 0, 0, 1},
		'{0, 8'h61, Z, ALL, 16'h000a, Z, 0, 0, 1},
		'{0, 8'h33, Z, ALL, 16'h00b4, Z, 0, 0, 1},
		'{0, 8'hd0, Z, ALL, 16'h0000, Z, 0, 0, 1},
		'{0, 8'hf9, Z, ALL, 16'h0004, Z, 0, 0, 1},
		'{0, 8'hee, Z, ALL, 16'h0000, Z, 0, 0, 1},
		'{0, 8'hef, Z, ALL, 16'h0000, Z, 0, 0, 1},
		'{0, 8'hf7, Z, ALL, 16'h0000, Z, 0, 0, 1},
		'{1, 8'h33, 16'h00c8, ALL, 16'h00c8, Z, 0, 0, 1},
		'{1, 8'h33, 16'h00c9, ALL, 16'h00c8, Z, 0, 0, 1},
		'{1, 8'h33, 16'h009f, ALL, 16'h00c8, Z, 0, 0, 1},
		'{1, 8'h12, ALL, ALL, Z, Z, 0, 0, 1},
		'{1, 8'hf7, 16'h0003, ALL, 16'h0003, Z, 0, 0, 1},
		'{0, 8'h79, Z, GD, GD, V9, 0, 0, 0},
		'{0, 8'h79, Z, GD, Z, V9, 0, 1, 1},
		'{0, 8'h79, Z, GD, GD, V9, 0, 0, 0},
		'{0, 8'h79, Z, GD, GD, 16'h1770, 0, 0, 0},
		'{0, 8'h79, Z, GD, Z, V4, 0, 0, 1},
		'{0, 8'h79, Z, GD, Z, 16'h1770, 0, 0, 1},
		'{0, 8'h79, Z, GD, Z, V9, 1, 0, 1},
		'{0, 8'h79, Z, GD, GD, V9, 0, 0, 0},
		'{1, 8'h5e, 16'h2710, ALL, 16'h2710, V4, 0, 0, 1},
		'{0, 8'h79, Z, GD, Z, V9, 0, 0, 1},
		'{0, 8'h79, Z, GD, GD, 16'h2af8, 0, 0, 0}
	};
	// band limits, two levels, ramp window, capacitance limits, factors
	logic [15:0] aux [AUX_COUNT] = '{16'h0064, 16'h0050, 16'h00c8,
		16'h00b4, 16'h2ec0, 16'h2ed0, 16'h03e8, 16'h07d0, 16'h0001,
		16'h0002, 16'h0003, 16'h0010, 16'h0010, 16'h0020};
	logic [15:0] cur [5] = '{16'h0096, 16'h00fa, 16'h00be, 16'h00aa,
		16'h005a};
	logic [15:0] lvl [5] = '{16'h2ed0, 16'h2ee0, 16'h2ee0, 16'h2ed0,
		16'h2ed0};

	////////////////////////////////////////////////////////////////////////
	// design and host model
	pgaoc_top #(.SLEW_TICK_CYCLES(8)) dut_u (.clk_in, .rst_in,
		.cmd_valid_in, .cmd_write_in, .cmd_code_in, .cmd_wdata_in,
		.cmd_ack_out, .cmd_rdata_out, .vout_meas_in, .iout_meas_in,
		.ramping_in, .fault_in, .good_or_sync_pin_out,
		.good_or_sync_pin_oe_n_out, .strap_second_pin_in,
		.strap_second_pin_out, .strap_second_pin_oe_n_out,
		.address_strap_first_in, .address_strap_second_in,
		.bus_address_out, .switch_tick_out, .vout_ref_out,
		.rise_time_out, .loop_alt_out, .cap_measure_out);

	pgaoc_host host_u (.clk_in, .cmd_valid_out(cmd_valid_in),
		.cmd_write_out(cmd_write_in), .cmd_code_out(cmd_code_in),
		.cmd_wdata_out(cmd_wdata_in), .cmd_ack_in(cmd_ack_out),
		.cmd_rdata_in(cmd_rdata_out));

	// 10 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////////////
	// checking and waiting
	task automatic close_out();
		$display("errors %0d, checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
			num_errors++;
		end
	endtask

	task automatic give_up();
		num_errors++;
		close_out();
	endtask

	task automatic cmd(input logic w, input logic [7:0] c,
		input logic [15:0] d);
		logic ok;
		host_u.xfer(w, c, d, ok, rd);
		chk({15'h0, ok}, 16'h0001);
	endtask

	task automatic wait_tick(output int k);
		k = 0;
		do begin
			@(negedge clk_in);
			k++;
			if (k > 100) give_up();
		end while (switch_tick_out !== 1'b1);
	endtask

	task automatic wait_ref(input logic [15:0] e, output int k);
		k = 0;
		while (vout_ref_out !== e) begin
			@(negedge clk_in);
			k++;
			if (k > 200) give_up();
		end
	endtask

	// one ramp with 1100 cycles inside the measuring window
	task automatic ramp(input logic alt);
		vout_meas_in = Z;
		repeat (2) @(negedge clk_in);
		ramping_in = 1'b1;
		repeat (2) @(negedge clk_in);
		chk(rise_time_out, 16'h000a);
		vout_meas_in = 16'h05dc;
		repeat (1100) @(negedge clk_in);
		vout_meas_in = 16'h09c4;
		repeat (4) @(negedge clk_in);
		chk(cap_measure_out, 16'h0004);
		chk(rise_time_out, 16'h0014);
		chk({15'h0, loop_alt_out}, {15'h0, alt});
		ramping_in = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_in = 1'b1;
		vout_meas_in = Z;
		iout_meas_in = Z;
		ramping_in = 1'b0;
		fault_in = 1'b0;
		strap_second_pin_in = 1'b0;
		address_strap_first_in = 7'h10;
		address_strap_second_in = 7'h05;
		repeat (2) @(negedge clk_in);
		rst_in = 1'b0;
		@(negedge clk_in);
		chk({13'h0, good_or_sync_pin_out, good_or_sync_pin_oe_n_out,
			strap_second_pin_oe_n_out}, 16'h0005);
		chk(vout_ref_out, 16'h2ee0);
		wait_tick(n);
		wait_tick(n);
		chk(16'(n), 16'h0037);
		// ordinary cases, one row per command or status step
		for (int i = 0; i < NROW; i++) begin
			vout_meas_in = rows[i].vout;
			ramping_in = rows[i].rmp;
			fault_in = rows[i].flt;
			if (rows[i].w === 1'b1) cmd(1'b1, rows[i].code, rows[i].wd);
			repeat (3) @(negedge clk_in);
			cmd(1'b0, rows[i].code, Z);
			chk(rd & rows[i].msk, rows[i].exp);
			chk({15'h0, good_or_sync_pin_out}, {15'h0, rows[i].pin});
		end
		wait_tick(n);
		wait_tick(n);
		chk(16'(n), 16'h0032);
		// polarity and drive kind of the good pin
		cmd(1'b1, 8'hd0, 16'h0001);
		repeat (3) @(negedge clk_in);
		chk({15'h0, good_or_sync_pin_out}, 16'h0001);
		cmd(1'b1, 8'hd0, Z);
		cmd(1'b1, 8'hf9, 16'h0006);
		repeat (3) @(negedge clk_in);
		chk({14'h0, good_or_sync_pin_out, good_or_sync_pin_oe_n_out}, Z);
		vout_meas_in = V4;
		repeat (3) @(negedge clk_in);
		chk({15'h0, good_or_sync_pin_oe_n_out}, 16'h0001);
		cmd(1'b1, 8'hf9, 16'h0004);
		repeat (3) @(negedge clk_in);
		chk({14'h0, good_or_sync_pin_out, good_or_sync_pin_oe_n_out},
			16'h0002);
		// address increment and second pin as sync
		chk({9'h0, bus_address_out}, 16'h0015);
		cmd(1'b1, 8'hee, 16'h0003);
		cmd(1'b1, 8'hf9, 16'h000c);
		repeat (3) @(negedge clk_in);
		chk({9'h0, bus_address_out}, 16'h0013);
		wait_tick(n);
		strap_second_pin_in = 1'b1;
		wait_tick(n);
		chk(16'(n <= 8), 16'h0001);
		strap_second_pin_in = 1'b0;
		cmd(1'b1, 8'hf9, 16'h001c);
		repeat (3) @(negedge clk_in);
		chk({15'h0, strap_second_pin_oe_n_out}, Z);
		wait_tick(n);
		@(negedge clk_in);
		chk({15'h0, strap_second_pin_out}, 16'h0001);
		cmd(1'b1, 8'hf9, 16'h0004);
		// load based levels, slewed at the transition rate
		for (int i = 0; i < AUX_COUNT; i++)
			cmd(1'b1, CMD_AUX_BASE + 8'(i), aux[i]);
		cmd(1'b1, 8'hef, 16'h0001);
		wait_ref(16'h2ec0, n);
		chk(16'(n >= 24 && n <= 41), 16'h0001);
		for (int i = 0; i < 5; i++) begin
			iout_meas_in = cur[i];
			repeat (40) @(negedge clk_in);
			chk(vout_ref_out, lvl[i]);
		end
		// ramp measurement with and without loop change
		ramp(1'b1);
		cmd(1'b1, 8'hf7, 16'h0001);
		ramp(1'b0);
		// reset in mid-run restores settings
		rst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		rst_in = 1'b0;
		@(negedge clk_in);
		chk(rise_time_out, 16'h000a);
		cmd(1'b0, 8'h33, Z);
		chk(rd, 16'h00b4);
		close_out();
	end
endmodule // tb_pgaoc_top
